/* design/amt_cfg.svh */
// Timing and reset constants for the pulse timer
`ifndef AMT_CFG_SVH
`define AMT_CFG_SVH

`define AMT_CNT_W       16
`define AMT_PERIOD_CYC  16'h0010
`define AMT_HALF_CYC    16'h0008
`define AMT_PERIOD_LAST 16'h000F
`define AMT_HALF_LAST   16'h0007
`define AMT_CNT_ZERO    16'h0000
`define AMT_CNT_ONE     16'h0001
`define AMT_PIN_W       6
`define AMT_SYNC_RST    6'h22

`endif

/* design/amt_pkg.sv */
// Types shared by the pulse timer modules
package amt_pkg;

  typedef enum logic [1:0] {
    AMT_IDLE  = 2'b00,
    AMT_RUN   = 2'b01,
    AMT_PULSE = 2'b10
  } amt_state_t;

  typedef struct packed {
    logic master_clear;
    logic re_arm_in;
    logic trig_fall;
    logic trig_rise;
    logic run_en_n;
    logic run_en;
  } amt_pins_t;

  typedef struct packed {
    logic osc_out;
    logic q_n;
    logic q;
  } amt_outs_t;

endpackage : amt_pkg

/* design/amt_sync_edge.sv */
// Two-flop input synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none

module amt_sync_edge #(
  parameter int unsigned   W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;

  // Only the second stage reads the first
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta   <= RST;
      stable <= RST;
      prev   <= RST;
    end
    else
    begin
      meta   <= async_in;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign level = stable;
  assign rise  = stable & ~prev;
  assign fall  = ~stable & prev;

endmodule : amt_sync_edge

`default_nettype wire

/* design/amt_timer.sv */
// Astable and one-shot pulse timer core
//
// Contract
// - A high free-run enable keeps the oscillator running with a square wave on q and q_n.
// - A high run_en or a low run_en_n gates the oscillator on for as long as it lasts.
// - In free run osc_out toggles at twice the rate of q, with a duty of one half.
// - q_n is always the inverse of q.
// - With trig_fall low, a rising edge on trig_rise fires a one-shot pulse.
// - With trig_rise high, a falling edge on trig_fall fires a one-shot pulse.
// - The one-shot width is the timing period, whatever the trigger's length.
// - A common rising edge on re_arm_in and trig_rise restarts the active pulse's period.
// - Re-arm edges spaced under one period keep q high without a break.
// - With the divider fed back the gate holds the oscillator for N periods.
// - While master_clear is high no pulse is produced.
// - Raising master_clear ends any pulse in progress at once.
`timescale 1ns/1ps
`default_nettype none
`include "amt_cfg.svh"

module amt_timer
  import amt_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire amt_pins_t pins_in,
  output amt_outs_t      outs
);

  logic [`AMT_PIN_W-1:0] lvl_v;
  logic [`AMT_PIN_W-1:0] rise_v;
  logic [`AMT_PIN_W-1:0] fall_v;
  amt_pins_t             lvl;
  amt_pins_t             rise;
  amt_pins_t             fall;
  amt_state_t            state;
  logic [`AMT_CNT_W-1:0] cnt;
  logic                  q;
  logic                  q_n;
  logic                  osc;
  logic                  gate;
  logic                  mclr;
  logic                  rise_trig;
  logic                  fall_trig;
  logic                  fire;
  logic                  retrig;
  logic                  last;
  logic                  half;

  amt_sync_edge #(
    .W   (`AMT_PIN_W),
    .RST (`AMT_SYNC_RST)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pins_in),
    .level    (lvl_v),
    .rise     (rise_v),
    .fall     (fall_v)
  );

  assign lvl  = amt_pins_t'(lvl_v);
  assign rise = amt_pins_t'(rise_v);
  assign fall = amt_pins_t'(fall_v);

  assign mclr      = lvl.master_clear;
  assign gate      = lvl.run_en | ~lvl.run_en_n;
  assign rise_trig = rise.trig_rise & ~lvl.trig_fall;
  assign fall_trig = fall.trig_fall & lvl.trig_rise;
  assign fire      = rise_trig | fall_trig;
  assign retrig    = rise.re_arm_in & rise.trig_rise;
  assign last      = (cnt == `AMT_PERIOD_LAST);
  assign half      = (cnt == `AMT_HALF_LAST);

  // Mode sequencing
  always_ff @(posedge clk)
  begin
    if (!reset_n || mclr)
      state <= AMT_IDLE;
    else
    begin
      case (state)
        AMT_IDLE:
        begin
          if (gate)
            state <= AMT_RUN;
          else if (fire)
            state <= AMT_PULSE;
        end
        AMT_RUN:
        begin
          if (!gate)
            state <= AMT_IDLE;
        end
        AMT_PULSE:
        begin
          if (last && !retrig)
            state <= AMT_IDLE;
        end
        default:
          state <= AMT_IDLE;
      endcase
    end
  end

  // Timing period counter
  always_ff @(posedge clk)
  begin
    if (!reset_n || mclr)
      cnt <= `AMT_CNT_ZERO;
    else
    begin
      case (state)
        AMT_RUN:
        begin
          if (!gate || last)
            cnt <= `AMT_CNT_ZERO;
          else
            cnt <= cnt + `AMT_CNT_ONE;
        end
        AMT_PULSE:
        begin
          if (retrig || last)
            cnt <= `AMT_CNT_ZERO;
          else
            cnt <= cnt + `AMT_CNT_ONE;
        end
        default:
          cnt <= `AMT_CNT_ZERO;
      endcase
    end
  end

  // True and complement outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n || mclr)
    begin
      q   <= 1'b0;
      q_n <= 1'b1;
    end
    else
    begin
      case (state)
        AMT_IDLE:
        begin
          if (!gate && fire)
          begin
            q   <= 1'b1;
            q_n <= 1'b0;
          end
        end
        AMT_RUN:
        begin
          if (!gate)
          begin
            q   <= 1'b0;
            q_n <= 1'b1;
          end
          else if (last)
          begin
            q   <= ~q;
            q_n <= q;
          end
        end
        AMT_PULSE:
        begin
          if (last && !retrig)
          begin
            q   <= 1'b0;
            q_n <= 1'b1;
          end
        end
        default:
        begin
          q   <= 1'b0;
          q_n <= 1'b1;
        end
      endcase
    end
  end

  // Oscillator tap
  always_ff @(posedge clk)
  begin
    if (!reset_n || mclr)
      osc <= 1'b0;
    else
    begin
      case (state)
        AMT_RUN:
        begin
          if (!gate)
            osc <= 1'b0;
          else if (half || last)
            osc <= ~osc;
        end
        AMT_PULSE:
        begin
          if (last && !retrig)
            osc <= 1'b0;
          else if (half || last)
            osc <= ~osc;
        end
        default:
          osc <= 1'b0;
      endcase
    end
  end

  assign outs = {osc, q_n, q};

  a_comp_inverse: assert property (@(posedge clk) disable iff (!reset_n)
    q_n == ~q)
    else $error("q_n not the inverse of q");

  a_free_run_toggle: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_RUN && gate && !mclr && last) |=> (q != $past(q)))
    else $error("free run q did not toggle at period end");

  a_gate_stops_run: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_RUN && !gate && !mclr) |=> (state == AMT_IDLE && !q && !osc))
    else $error("oscillator kept running after gate dropped");

  a_gate_starts_run: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_IDLE && gate && !mclr) |=> (state == AMT_RUN))
    else $error("gate did not start the oscillator");

  a_osc_twice_rate: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_RUN && gate && !mclr && half) |=> (osc != $past(osc) && q == $past(q)))
    else $error("oscillator tap did not toggle mid period");

  a_rise_fires: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_IDLE && !gate && !mclr && rise_trig) |=> (state == AMT_PULSE && q))
    else $error("rising trigger did not fire a pulse");

  a_fall_fires: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_IDLE && !gate && !mclr && fall_trig) |=> (state == AMT_PULSE && q))
    else $error("falling trigger did not fire a pulse");

  a_pulse_width_end: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_PULSE && last && !retrig && !mclr) |=> (!q && state == AMT_IDLE))
    else $error("one-shot did not end at period");

  a_pulse_high: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_PULSE) |-> q)
    else $error("q low during one-shot");

  a_retrig_restart: assert property (@(posedge clk) disable iff (!reset_n)
    (state == AMT_PULSE && retrig && !mclr) |=> (cnt == `AMT_CNT_ZERO && q))
    else $error("re-arm did not restart the period");

  a_clear_kills: assert property (@(posedge clk) disable iff (!reset_n)
    mclr |=> (!q && !osc && state == AMT_IDLE))
    else $error("master clear did not end output");

  a_count_bound: assert property (@(posedge clk) disable iff (!reset_n)
    cnt < `AMT_PERIOD_CYC)
    else $error("period counter out of range");

endmodule : amt_timer

`default_nettype wire

/* test/amt_div_model.sv */
// External divide-by-N counter fed back to the inverted gate
`timescale 1ns/1ps
`default_nettype none

module amt_div_model #(
  parameter int N = 3
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic q,
  input  wire logic start,
  output logic      run_en_n
);
  logic q_d;
  int   cnt;

  // Cleared by the trigger, counts q periods, gates for N of them
  always_ff @(posedge clk)
  begin
    q_d <= q;
    if (!reset_n || start)
    begin
      cnt      <= 0;
      run_en_n <= !start;
    end
    else if (!run_en_n && q_d && !q)
    begin
      cnt <= cnt + 1;
      if (cnt == N - 1)
        run_en_n <= 1'b1;
    end
  end
endmodule : amt_div_model

`default_nettype wire

/* test/amt_timer_tb_top.sv */
// Self-checking bench for the pulse timer
`timescale 1ns/1ps
`default_nettype none
`include "amt_cfg.svh"

`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module amt_timer_tb_top
  import amt_pkg::*;
;
  localparam int P = `AMT_PERIOD_CYC;
  localparam int H = `AMT_HALF_CYC;
  localparam int N = 3;
  logic      clk;
  logic      reset_n;
  logic      start;
  logic      div_n;
  amt_pins_t pins;
  amt_pins_t pins_in;
  amt_outs_t outs;
  int        fail_count;
  int        samples_checked;

  assign pins_in = {pins[5:2], pins.run_en_n & div_n, pins.run_en};

  amt_timer dut (.clk(clk), .reset_n(reset_n), .pins_in(pins_in), .outs(outs));
  amt_div_model #(.N(N)) div (.clk(clk), .reset_n(reset_n), .q(outs.q), .start(start),
    .run_en_n(div_n));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic wait_q(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && outs.q !== v; i++)
      step(1);
    `CHK("q", v, outs.q)
  endtask : wait_q

  task automatic run_len(input int b, input logic v, output int n);
    int i;
    n = 0;
    for (i = 0; i < 60 && outs[b] !== v; i++)
      step(1);
    while (outs[b] === v && n < 400)
    begin
      step(1);
      n++;
    end
  endtask : run_len

  task automatic quiet(input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      step(1);
      if (outs.q !== 1'b0)
        bad = 1;
    end
    `CHK("q_quiet", 0, bad)
  endtask : quiet

  task automatic t_free_run;
    int n;
    @(posedge clk) pins.run_en <= 1'b1;
    run_len(0, 1'b1, n);
    `CHK("q_high", P, n)
    run_len(2, 1'b0, n);
    run_len(2, 1'b1, n);
    `CHK("osc_high", H, n)
    wait_q(1'b1, 40);
    `CHK("q_n", 1'b0, outs.q_n)
    @(posedge clk) pins.run_en <= 1'b0;
    wait_q(1'b0, 4);
    quiet(30);
    $display("test free_run done");
  endtask : t_free_run

  task automatic t_gate_n;
    int n;
    @(posedge clk) pins.run_en_n <= 1'b0;
    run_len(0, 1'b1, n);
    `CHK("gate_n_high", P, n)
    wait_q(1'b1, 40);
    @(posedge clk) pins.run_en_n <= 1'b1;
    wait_q(1'b0, 4);
    quiet(30);
    $display("test gate_n done");
  endtask : t_gate_n

  task automatic t_shots;
    int n;
    @(posedge clk) pins.trig_rise <= 1'b1;
    run_len(0, 1'b1, n);
    `CHK("rise_width", P, n)
    `CHK("q_n", 1'b1, outs.q_n)
    @(posedge clk) pins.trig_rise <= 1'b0;
    quiet(20);
    @(posedge clk) pins.trig_fall <= 1'b1;
    step(4);
    @(posedge clk) pins.trig_rise <= 1'b1;
    quiet(6);
    @(posedge clk) pins.trig_fall <= 1'b0;
    run_len(0, 1'b1, n);
    `CHK("fall_width", P, n)
    @(posedge clk) pins.trig_rise <= 1'b0;
    quiet(20);
    $display("test shots done");
  endtask : t_shots

  task automatic t_re_arm;
    int n;
    fork
      run_len(0, 1'b1, n);
      begin
        @(posedge clk) pins.trig_rise <= 1'b1;
        repeat (3)
        begin
          repeat (4) @(posedge clk);
          pins.trig_rise <= 1'b0;
          pins.re_arm_in <= 1'b0;
          repeat (4) @(posedge clk);
          pins.trig_rise <= 1'b1;
          pins.re_arm_in <= 1'b1;
        end
      end
    join
    `CHK("re_arm_width", 3 * 8 + P, n)
    @(posedge clk) pins.re_arm_in <= 1'b0;
    pins.trig_rise <= 1'b0;
    quiet(20);
    $display("test re_arm done");
  endtask : t_re_arm

  task automatic t_clear;
    @(posedge clk) pins.trig_rise <= 1'b1;
    wait_q(1'b1, 5);
    step(4);
    @(posedge clk) pins.master_clear <= 1'b1;
    wait_q(1'b0, 4);
    @(posedge clk) pins.trig_rise <= 1'b0;
    step(3);
    @(posedge clk) pins.trig_rise <= 1'b1;
    quiet(30);
    @(posedge clk) pins.master_clear <= 1'b0;
    @(posedge clk) pins.trig_rise <= 1'b0;
    quiet(20);
    $display("test clear done");
  endtask : t_clear

  task automatic t_divider;
    int   n;
    logic last;
    n = 0;
    last = 1'b0;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (2 * N * P + 60)
    begin
      step(1);
      if (outs.q === 1'b1 && last !== 1'b1)
        n++;
      last = outs.q;
    end
    `CHK("div_pulses", N, n)
    $display("test divider done");
  endtask : t_divider

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    start = 1'b0;
    pins = `AMT_SYNC_RST;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    step(1);
    `CHK("q_idle", 1'b0, outs.q)
    `CHK("q_n_idle", 1'b1, outs.q_n)
    @(posedge clk) pins.master_clear <= 1'b0;
    step(10);
    t_free_run();
    t_gate_n();
    t_shots();
    t_re_arm();
    t_clear();
    t_divider();
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule : amt_timer_tb_top

`default_nettype wire
